// ### hw/rcla_pkg.sv
// package: offsets, field positions and reset values of the configuration latch array
package rcla_pkg;
	// Summary of operation
	// RQ1: four latch bytes hold configuration applied each time the device leaves reset.
	// RQ2: byte 0 ports 0-3, byte 1 ports 4,5,6,12, byte 2 bits 5:4 port 15.
	// RQ3: drive mode 00 analog hi-z default, 01 digital hi-z, 10 pull-up, 11 pull-down.
	// RQ4: one drive mode applies to every pin of its port.
	// RQ5: byte 2 bit 7 makes the shared pin GPIO at 0, external reset at 1.
	// RQ6: byte 2 bit 6 disables debug access at 0, enables at 1; default 1.
	// RQ7: byte 3 bits 2:1 pick 5-wire JTAG, 4-wire JTAG default, SWD, or none.
	// RQ8: byte 3 bit 3 enables ECC at 1 default; 0 frees spare flash for data.
	// RQ9: byte 3 bits 7:4 select digital clock phase delay.
	// RQ10: byte 3 bit 0 speed bit is stored and exported unchanged.
	// RQ11: latches sampled in the first cycle after reset release, driven onto outputs in the second, stable until the next reset.
	// register indices; the byte address on the bus is four times the index
	localparam logic [31:0] OFF_PORT_MODE_LOW  = 32'h0000_0000;
	localparam logic [31:0] OFF_PORT_MODE_MID  = 32'h0000_0001;
	localparam logic [31:0] OFF_RESET_DEBUG    = 32'h0000_0002;
	localparam logic [31:0] OFF_CLOCK_ECC_DBG  = 32'h0000_0003;
	localparam logic [31:0] OFF_APPLIED_STATUS = 32'h0000_0004;
	localparam int          NUM_PORTS          = 9;
	localparam int          POS_P15_MODE       = 4;
	localparam int          POS_EXT_RESET_SEL  = 7;
	localparam int          POS_DEBUG_ALLOW    = 6;
	localparam int          POS_SPEED          = 0;
	localparam int          POS_DEBUG_PORT     = 1;
	localparam int          POS_ECC_USE        = 3;
	localparam int          POS_PHASE_DLY      = 4;
	localparam logic [7:0]  RST_PORT_MODE_LOW  = 8'h00;
	localparam logic [7:0]  RST_PORT_MODE_MID  = 8'h00;
	localparam logic [7:0]  RST_RESET_DEBUG    = 8'h40;
	localparam logic [7:0]  RST_CLOCK_ECC_DBG  = 8'h0a;
	localparam logic [1:0]  MODE_HIZ_ANALOG    = 2'h0;
	localparam logic [1:0]  MODE_HIZ_DIGITAL   = 2'h1;
	localparam logic [1:0]  MODE_PULL_UP       = 2'h2;
	localparam logic [1:0]  MODE_PULL_DOWN     = 2'h3;
	localparam logic [1:0]  DBG_JTAG5          = 2'h0;
	localparam logic [1:0]  DBG_JTAG4          = 2'h1;
	localparam logic [1:0]  DBG_SWD            = 2'h2;
	localparam logic [1:0]  DBG_NONE           = 2'h3;
endpackage

// ### hw/rcla_top.sv
// configuration latch array with AHB-Lite access and reset-time capture
`timescale 1ns/1ns
module rcla_top #(
	parameter int PINS_PER_PORT = 8
) (
	input  wire logic                                 hclk,         // 25 MHz
	input  wire logic                                 hresetn,      // async, low
	input  wire logic                                 hsel,         // slave select
	input  wire logic [31:0]                          haddr,        // byte address
	input  wire logic [1:0]                           htrans,       // transfer type
	input  wire logic                                 hwrite,       // write
	input  wire logic [2:0]                           hsize,        // size
	input  wire logic [31:0]                          hwdata,       // write data
	input  wire logic                                 hready,       // bus ready
	output logic      [31:0]                          hrdata,       // read data
	output logic                                      hreadyout,    // always ready
	output logic                                      hresp,        // always OKAY
	output logic [rcla_pkg::NUM_PORTS*PINS_PER_PORT*2-1:0] pin_drive_mode, // per pin
	output logic                                      ext_reset_pin_select, // 1: reset pin
	output logic                                      debug_access_allow,   // 1: debug on
	output logic      [1:0]                           debug_port_select,    // port choice
	output logic                                      flash_ecc_use,        // 1: ECC
	output logic      [3:0]                           digital_clock_phase_delay, // delay
	output logic                                      config_speed_bit      // passed through
);
	localparam int NP = rcla_pkg::NUM_PORTS;

	// power-on factory contents; hresetn never reloads them
	logic [7:0]  config_latch_array_r [4] = '{rcla_pkg::RST_PORT_MODE_LOW,
		rcla_pkg::RST_PORT_MODE_MID, rcla_pkg::RST_RESET_DEBUG, rcla_pkg::RST_CLOCK_ECC_DBG};
	logic [7:0]  applied_r [4];
	logic        dphase_r;
	logic        dwrite_r;
	logic [2:0]  dindex_r;
	logic        addr_ok;
	logic [2:0]  aindex;
	logic [1:0]  port_reset_drive_mode [NP];

	// address phase decode
	assign aindex  = haddr[4:2];
	assign addr_ok = (haddr[31:5] == 27'h000_0000) && (haddr[1:0] == 2'h0) && (aindex <= 3'h4);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dphase_r <= 1'b0;
			dwrite_r <= 1'b0;
			dindex_r <= 3'h0;
		end else begin
			dphase_r <= hsel && htrans[1] && hready;
			dwrite_r <= hsel && htrans[1] && hready && hwrite && addr_ok;
			dindex_r <= addr_ok ? aindex : 3'h7;
		end
	end

	// nonvolatile: contents survive hresetn so that writes take effect at the next reset
	always_ff @(posedge hclk) begin
		if (dwrite_r && dindex_r < 3'h4) begin
			config_latch_array_r[dindex_r[1:0]] <= hwdata[7:0]; // RQ1
		end
	end

	// applied copy: tracks latches only while in reset-release cycle
	logic boot_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_r <= 1'b1;
		end else begin
			boot_r <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			applied_r[0] <= rcla_pkg::RST_PORT_MODE_LOW;
			applied_r[1] <= rcla_pkg::RST_PORT_MODE_MID;
			applied_r[2] <= rcla_pkg::RST_RESET_DEBUG;
			applied_r[3] <= rcla_pkg::RST_CLOCK_ECC_DBG;
		end else if (boot_r) begin
			// later writes are not applied until the next reset
			applied_r <= config_latch_array_r; // RQ11
		end
	end

	// byte 2 bits 3:0 are unused
	assign port_reset_drive_mode[0] = applied_r[0][1:0]; // RQ2
	assign port_reset_drive_mode[1] = applied_r[0][3:2];
	assign port_reset_drive_mode[2] = applied_r[0][5:4];
	assign port_reset_drive_mode[3] = applied_r[0][7:6];
	assign port_reset_drive_mode[4] = applied_r[1][1:0];
	assign port_reset_drive_mode[5] = applied_r[1][3:2];
	assign port_reset_drive_mode[6] = applied_r[1][5:4];
	assign port_reset_drive_mode[7] = applied_r[1][7:6];
	assign port_reset_drive_mode[8] = applied_r[2][rcla_pkg::POS_P15_MODE +: 2];

	// per-pin drive registers, every pin of a port gets the same code
	genvar gp, gi;
	generate
		for (gp = 0; gp < NP; gp++) begin : g_port
			for (gi = 0; gi < PINS_PER_PORT; gi++) begin : g_pin
				always_ff @(posedge hclk or negedge hresetn) begin
					if (!hresetn) begin
						pin_drive_mode[(gp*PINS_PER_PORT+gi)*2 +: 2] <= rcla_pkg::MODE_HIZ_ANALOG; // RQ3
					end else begin
						pin_drive_mode[(gp*PINS_PER_PORT+gi)*2 +: 2] <= port_reset_drive_mode[gp]; // RQ4
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ext_reset_pin_select      <= rcla_pkg::RST_RESET_DEBUG[rcla_pkg::POS_EXT_RESET_SEL];
			debug_access_allow        <= rcla_pkg::RST_RESET_DEBUG[rcla_pkg::POS_DEBUG_ALLOW];
			debug_port_select         <= rcla_pkg::DBG_JTAG4;
			flash_ecc_use             <= rcla_pkg::RST_CLOCK_ECC_DBG[rcla_pkg::POS_ECC_USE];
			digital_clock_phase_delay <= rcla_pkg::RST_CLOCK_ECC_DBG[rcla_pkg::POS_PHASE_DLY +: 4];
			config_speed_bit          <= rcla_pkg::RST_CLOCK_ECC_DBG[rcla_pkg::POS_SPEED];
		end else begin
			ext_reset_pin_select      <= applied_r[2][rcla_pkg::POS_EXT_RESET_SEL];   // RQ5
			debug_access_allow        <= applied_r[2][rcla_pkg::POS_DEBUG_ALLOW];     // RQ6
			debug_port_select         <= applied_r[3][rcla_pkg::POS_DEBUG_PORT +: 2]; // RQ7
			flash_ecc_use             <= applied_r[3][rcla_pkg::POS_ECC_USE];         // RQ8
			digital_clock_phase_delay <= applied_r[3][rcla_pkg::POS_PHASE_DLY +: 4];  // RQ9
			config_speed_bit          <= applied_r[3][rcla_pkg::POS_SPEED];           // RQ10
		end
	end

	// read data registered in the data phase would cost a wait state; use zero-wait mux
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (aindex)
			rcla_pkg::OFF_PORT_MODE_LOW[2:0]: rd_mux = {24'h00_0000, config_latch_array_r[0]};
			rcla_pkg::OFF_PORT_MODE_MID[2:0]: rd_mux = {24'h00_0000, config_latch_array_r[1]};
			rcla_pkg::OFF_RESET_DEBUG[2:0]: rd_mux = {24'h00_0000, config_latch_array_r[2]};
			rcla_pkg::OFF_CLOCK_ECC_DBG[2:0]: rd_mux = {24'h00_0000, config_latch_array_r[3]};
			rcla_pkg::OFF_APPLIED_STATUS[2:0]: rd_mux = {applied_r[3], applied_r[2],
				applied_r[1], applied_r[0]};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hsel && htrans[1] && hready && !hwrite && addr_ok) begin
				hrdata <= rd_mux;
			end else if (hsel && htrans[1] && hready) begin
				hrdata <= 32'h0000_0000;
			end
		end
	end

	// checks
	property p_debug_hold;
		@(posedge hclk)
		disable iff (!hresetn)
		!boot_r && !$past(boot_r) && !$past(boot_r, 2) |-> $stable(debug_access_allow);
	endproperty
	a_debug_hold: assert property (p_debug_hold) // RQ11
		else $error("debug allow changed after reset");

	property p_ecc_hold;
		@(posedge hclk)
		disable iff (!hresetn)
		!boot_r && !$past(boot_r) && !$past(boot_r, 2) |-> $stable(flash_ecc_use);
	endproperty
	a_ecc_hold: assert property (p_ecc_hold) // RQ8
		else $error("ecc use changed after reset");

	property p_pin_same;
		@(posedge hclk)
		disable iff (!hresetn)
		pin_drive_mode[1:0] == pin_drive_mode[PINS_PER_PORT*2-1 -: 2];
	endproperty
	a_pin_same: assert property (p_pin_same) // RQ4
		else $error("pins of port 0 differ");

	property p_port0;
		@(posedge hclk)
		disable iff (!hresetn)
		##1 !boot_r |-> pin_drive_mode[1:0] == $past(applied_r[0][1:0]);
	endproperty
	a_port0: assert property (p_port0) // RQ2
		else $error("port 0 mode wrong");

	property p_port15;
		@(posedge hclk)
		disable iff (!hresetn)
		pin_drive_mode[NP*PINS_PER_PORT*2-1 -: 2] == $past(applied_r[2][5:4]);
	endproperty
	a_port15: assert property (p_port15) // RQ2
		else $error("port 15 mode wrong");

	property p_ext;
		@(posedge hclk)
		disable iff (!hresetn)
		ext_reset_pin_select == $past(applied_r[2][7]);
	endproperty
	a_ext: assert property (p_ext) // RQ5
		else $error("ext reset select wrong");

	property p_dps;
		@(posedge hclk)
		disable iff (!hresetn)
		debug_port_select == $past(applied_r[3][2:1]);
	endproperty
	a_dps: assert property (p_dps) // RQ7
		else $error("debug port select wrong");

	property p_dly;
		@(posedge hclk)
		disable iff (!hresetn)
		digital_clock_phase_delay == $past(applied_r[3][7:4]);
	endproperty
	a_dly: assert property (p_dly) // RQ9
		else $error("phase delay wrong");

	property p_spd;
		@(posedge hclk)
		disable iff (!hresetn)
		config_speed_bit == $past(applied_r[3][0]);
	endproperty
	a_spd: assert property (p_spd) // RQ10
		else $error("speed bit wrong");

	property p_ready;
		@(posedge hclk)
		disable iff (!hresetn)
		hreadyout && !hresp;
	endproperty
	a_ready: assert property (p_ready) // RQ1
		else $error("slave not ready or error");

	property p_unmapped_zero;
		@(posedge hclk)
		disable iff (!hresetn)
		dphase_r && dindex_r == 3'h7 |-> hrdata == 32'h0000_0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) // RQ1
		else $error("unmapped access returned nonzero data");

	property p_latch_write;
		@(posedge hclk)
		disable iff (!hresetn)
		dwrite_r && dindex_r < 3'h4 |=>
			config_latch_array_r[$past(dindex_r[1:0])] == $past(hwdata[7:0]);
	endproperty
	a_latch_write: assert property (p_latch_write) // RQ1
		else $error("latch write did not land");

	property p_latch_keep;
		@(posedge hclk)
		disable iff (!hresetn)
		!dwrite_r |=> $stable({config_latch_array_r[3], config_latch_array_r[2],
			config_latch_array_r[1], config_latch_array_r[0]});
	endproperty
	a_latch_keep: assert property (p_latch_keep) // RQ1
		else $error("latch changed without a write");

	property p_applied_hold;
		@(posedge hclk)
		disable iff (!hresetn)
		!boot_r |=> $stable({applied_r[3], applied_r[2], applied_r[1], applied_r[0]});
	endproperty
	a_applied_hold: assert property (p_applied_hold) // RQ11
		else $error("applied copy changed after reset");

	property p_cfg_hold;
		@(posedge hclk)
		disable iff (!hresetn)
		!boot_r && !$past(boot_r) && !$past(boot_r, 2) |-> $stable({ext_reset_pin_select,
			debug_port_select, digital_clock_phase_delay, config_speed_bit, pin_drive_mode});
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) // RQ11
		else $error("configuration outputs changed after reset");

	property p_port12;
		@(posedge hclk)
		disable iff (!hresetn)
		pin_drive_mode[8*PINS_PER_PORT*2-1 -: 2] == $past(applied_r[1][7:6]);
	endproperty
	a_port12: assert property (p_port12) // RQ2
		else $error("port 12 mode wrong");

	property p_status_read;
		@(posedge hclk)
		disable iff (!hresetn)
		hsel && htrans[1] && hready && !hwrite && haddr == {rcla_pkg::OFF_APPLIED_STATUS[29:0], 2'h0}
			|=> hrdata == $past({applied_r[3], applied_r[2], applied_r[1], applied_r[0]});
	endproperty
	a_status_read: assert property (p_status_read) // RQ11
		else $error("applied status read wrong");

	// main scenarios: writes, rare debug codes, pull-down reset mode
	c_write: cover property (@(posedge hclk) disable iff (!hresetn) dwrite_r);
	c_swd: cover property (@(posedge hclk) disable iff (!hresetn)
		debug_port_select == rcla_pkg::DBG_SWD);
	c_nodbg: cover property (@(posedge hclk) disable iff (!hresetn) !debug_access_allow);
	c_pull_down: cover property (@(posedge hclk) disable iff (!hresetn)
		pin_drive_mode[NP*PINS_PER_PORT*2-1 -: 2] == rcla_pkg::MODE_PULL_DOWN);
endmodule

// ### tb/rcla_tb.sv
// self-checking testbench for the configuration latch array over AHB-Lite
`timescale 1ns/1ns
module tb;
	localparam int PPP = 8;
	localparam int PW  = rcla_pkg::NUM_PORTS * PPP * 2;
	logic          hclk;
	logic          hresetn;
	logic          hsel;
	logic [31:0]   haddr;
	logic [1:0]    htrans;
	logic          hwrite;
	logic [2:0]    hsize;
	logic [31:0]   hwdata;
	logic [31:0]   hrdata;
	logic          hreadyout;
	logic          hresp;
	logic [PW-1:0] pin_drive_mode;
	logic          ext_reset_pin_select;
	logic          debug_access_allow;
	logic [1:0]    debug_port_select;
	logic          flash_ecc_use;
	logic [3:0]    digital_clock_phase_delay;
	logic          config_speed_bit;
	int            errors;
	int            check_count;
	logic [31:0]   rd;
	// byte addresses: four times each register's index
	logic [31:0]   offs [4] = '{rcla_pkg::OFF_PORT_MODE_LOW << 2,
		rcla_pkg::OFF_PORT_MODE_MID << 2, rcla_pkg::OFF_RESET_DEBUG << 2,
		rcla_pkg::OFF_CLOCK_ECC_DBG << 2};
	logic [7:0]    rsts [4] = '{rcla_pkg::RST_PORT_MODE_LOW, rcla_pkg::RST_PORT_MODE_MID,
		rcla_pkg::RST_RESET_DEBUG, rcla_pkg::RST_CLOCK_ECC_DBG};
	// every drive mode code appears in byte 0; byte 3 selects only the SWD debug port code
	logic [31:0]   wv [4] = '{32'ha5a5_a5e4, 32'h5a5a_5a1b, 32'hffff_ffb0, 32'h0000_0075};

	rcla_top #(.PINS_PER_PORT(PPP)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pin_drive_mode(pin_drive_mode), .ext_reset_pin_select(ext_reset_pin_select),
		.debug_access_allow(debug_access_allow), .debug_port_select(debug_port_select),
		.flash_ecc_use(flash_ecc_use), .digital_clock_phase_delay(digital_clock_phase_delay),
		.config_speed_bit(config_speed_bit));

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// entered just after a rising edge; holds each phase until hready is seen high
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rdv);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rdv = hrdata;
	endtask

	task automatic check_cfg(input logic [7:0] b0, b1, b2, b3);
		logic [PW-1:0] exp;
		logic [1:0]    m [rcla_pkg::NUM_PORTS];
		m = '{b0[1:0], b0[3:2], b0[5:4], b0[7:6], b1[1:0], b1[3:2], b1[5:4], b1[7:6], b2[5:4]};
		for (int i = 0; i < PW / 2; i++)
			exp[i*2+:2] = m[i/PPP];
		check_count++;
		if (pin_drive_mode !== exp) begin
			errors++;
			$display("Error pin_drive_mode expected %h seen %h", exp, pin_drive_mode);
		end
		check("config outputs", {22'h00_0000, b2[7], b2[6], b3[2:1], b3[3], b3[7:4], b3[0]},
			{22'h00_0000, ext_reset_pin_select, debug_access_allow, debug_port_select,
			flash_ecc_use, digital_clock_phase_delay, config_speed_bit});
	endtask

	// b holds the latch bytes expected to be applied, byte 3 down to byte 0
	task automatic do_reset(input logic [31:0] b);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		// applied copy at the first edge, outputs at the second, settled at the third
		repeat (3) @(posedge hclk);
		check_cfg(b[7:0], b[15:8], b[23:16], b[31:24]);
		for (int i = 0; i < 4; i++) begin
			ahb(1'b0, offs[i], 32'h0000_0000, rd);
			check("latch after reset", {24'h00_0000, b[i*8+:8]}, rd);
		end
		ahb(1'b0, rcla_pkg::OFF_APPLIED_STATUS << 2, 32'h0000_0000, rd);
		check("applied after reset", b, rd);
	endtask

	initial begin
		hresetn     = 1'b0;
		hsel        = 1'b0;
		haddr       = 32'h0000_0000;
		htrans      = 2'h0;
		hwrite      = 1'b0;
		hsize       = 3'h2;
		hwdata      = 32'h0000_0000;
		errors      = 0;
		check_count = 0;
		@(posedge hclk);
		do_reset({rsts[3], rsts[2], rsts[1], rsts[0]});
		for (int i = 0; i < 4; i++)
			ahb(1'b1, offs[i], wv[i], rd);
		for (int i = 0; i < 4; i++) begin
			ahb(1'b0, offs[i], 32'h0000_0000, rd);
			check("latch readback", {24'h00_0000, wv[i][7:0]}, rd);
		end
		check("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
		// rewrites after release must not reach the applied configuration
		check_cfg(rsts[0], rsts[1], rsts[2], rsts[3]);
		ahb(1'b1, rcla_pkg::OFF_APPLIED_STATUS << 2, 32'hffff_ffff, rd);
		ahb(1'b0, rcla_pkg::OFF_APPLIED_STATUS << 2, 32'h0000_0000, rd);
		check("applied status", {rsts[3], rsts[2], rsts[1], rsts[0]}, rd);
		ahb(1'b1, 32'h0000_0020, 32'hffff_ffff, rd);
		ahb(1'b0, 32'h0000_0020, 32'h0000_0000, rd);
		check("unmapped read", 32'h0000_0000, rd);
		// latches survive reset, so the rewritten bytes are applied now
		do_reset({wv[3][7:0], wv[2][7:0], wv[1][7:0], wv[0][7:0]});
		complete_run();
	end

	initial begin
		repeat (2000) @(posedge hclk);
		errors++;
		complete_run();
	end
endmodule
